// ### rtl/configurable_ram_blocks.sv
// configurable embedded ram: mid-size or large block, one shape per build
// assumes: fabric logic drives both ports on mclk and picks a legal shape
//
// How it works
// - mid block shapes 4K x1 down to 128 x32 or x36.
// - mid block true dual-port excludes the 128-deep shapes.
// - mid simple dual-port pairs any widths inside one width set.
// - mid true dual-port pairs widths up to 16 or 18 inside one set.
// - mid shift register holds taps times depth times width up to 4,608 bits.
// - large block stores 589,824 bits, parity bits included.
// - large block runs true dual, simple dual, single port or fifo.
// - large block has no initial contents; unwritten words are undefined.
// - all inputs, address, data, enables, are registered on the clock.
// - output register per port may be kept or bypassed.
// - large block shapes 64K x8 or x9 down to 4K x128 or x144.
// - 4K x128 true dual-port only beside x8 or x16; only 144 read drivers exist.
// - large simple dual-port pairs 9 to 72; 144 pairs with itself.
`timescale 1ns/1ps
module configurable_ram_blocks
  import ram_cfg_pkg::*;
#(
  parameter blk_kind_e KIND        = BLK_MID,
  parameter ram_mode_e MODE        = MODE_TDP,
  parameter int        WIDTH_A     = 16,
  parameter int        WIDTH_B     = 16,
  parameter bit        OUT_REG_A   = 1'b1,
  parameter bit        OUT_REG_B   = 1'b1,
  parameter int        SHIFT_W     = 8,
  parameter int        SHIFT_DEPTH = 64,
  parameter int        SHIFT_TAPS  = 2,
  localparam int       AW_A        = $clog2(depth_of(KIND, WIDTH_A)),
  localparam int       AW_B        = $clog2(depth_of(KIND, WIDTH_B))
) (
  input  wire logic               mclk,
  input  wire logic               reset_n,
  input  wire logic               a_en,
  input  wire logic               a_we,
  input  wire logic [AW_A-1:0]    a_addr,
  input  wire logic [WIDTH_A-1:0] a_wdata,
  output logic      [WIDTH_A-1:0] a_rdata,
  input  wire logic               b_en,
  input  wire logic               b_we,
  input  wire logic [AW_B-1:0]    b_addr,
  input  wire logic [WIDTH_B-1:0] b_wdata,
  output logic      [WIDTH_B-1:0] b_rdata,
  output logic                    fifo_full,
  output logic                    fifo_empty
);

  // ****************************************************************
  // derived sizes
  // ****************************************************************
  localparam int DEPTH_A  = depth_of(KIND, WIDTH_A);
  localparam int MEM_BITS = (KIND == BLK_LARGE) ? LARGE_PAR_BITS : MID_PAR_BITS;
  localparam int SH_LEN   = SHIFT_TAPS * SHIFT_DEPTH;
  localparam int SH_AW    = (SH_LEN > 1) ? $clog2(SH_LEN) : 1;
  localparam int CW       = AW_A + 1;
  localparam int LAT_A    = OUT_REG_A ? 2 : 1;
  localparam int LAT_B    = OUT_REG_B ? 2 : 1;
  localparam bit SHIFT_OK = SH_LEN * SHIFT_W <= SHIFT_MAX_BITS
                            && SHIFT_TAPS * SHIFT_W <= WIDTH_A;
  localparam bit LEGAL    = pair_ok(KIND, MODE, WIDTH_A, WIDTH_B)
                            && (MODE != MODE_SHIFT || SHIFT_OK);

  // ****************************************************************
  // port units
  // ****************************************************************
  ram_port_if #(.W(WIDTH_A), .AW(AW_A)) pa ();
  ram_port_if #(.W(WIDTH_B), .AW(AW_B)) pb ();

  ram_port_unit #(
    .W       (WIDTH_A),
    .AW      (AW_A),
    .OUT_REG (OUT_REG_A)
  ) u_port_a (
    .mclk    (mclk),
    .reset_n (reset_n),
    .en      (a_en),
    .we      (a_we),
    .addr    (a_addr),
    .wdata   (a_wdata),
    .p       (pa),
    .rdata   (a_rdata)
  );

  ram_port_unit #(
    .W       (WIDTH_B),
    .AW      (AW_B),
    .OUT_REG (OUT_REG_B)
  ) u_port_b (
    .mclk    (mclk),
    .reset_n (reset_n),
    .en      (b_en),
    .we      (b_we),
    .addr    (b_addr),
    .wdata   (b_wdata),
    .p       (pb),
    .rdata   (b_rdata)
  );

  // ****************************************************************
  // storage and mode steering
  // ****************************************************************
  logic             mem [MEM_BITS];
  logic             a_wr;
  logic             a_rl;
  logic             b_wr;
  logic             b_rl;
  logic [AW_A-1:0]  a_ent;
  logic [AW_B-1:0]  b_ent;
  int               a_base;
  int               b_base;
  logic [AW_A-1:0]  wp_r;
  logic [AW_B-1:0]  rp_r;
  logic [CW-1:0]    cnt_r;
  logic [CW-1:0]    cnt_nxt;
  logic             full_r;
  logic             empty_r;
  logic [SH_AW-1:0] sh_ptr_r;
  logic             push;
  logic             pop;

  // each mode decides which port writes and which reads
  always_comb begin
    a_wr  = pa.en_q & pa.we_q;
    a_rl  = pa.en_q & ~pa.we_q;
    a_ent = pa.addr_q;
    b_wr  = pb.en_q & pb.we_q;
    b_rl  = pb.en_q & ~pb.we_q;
    b_ent = pb.addr_q;
    case (MODE)
      MODE_SDP: begin
        a_rl = 1'b0; // port a writes only
        b_wr = 1'b0; // port b reads only
      end
      MODE_SP: begin
        b_wr = 1'b0;
        b_rl = 1'b0;
      end
      MODE_FIFO: begin
        a_wr  = pa.en_q & ~full_r; // push refused when full
        a_rl  = 1'b0;
        a_ent = wp_r;
        b_wr  = 1'b0;
        b_rl  = pb.en_q & ~empty_r; // pop refused when empty
        b_ent = rp_r;
      end
      MODE_SHIFT: begin
        a_wr = pa.en_q; // each enable shifts one word
        a_rl = pa.en_q;
        b_wr = 1'b0;
        b_rl = 1'b0;
      end
      default: begin
      end
    endcase
  end

  // bit address of each port; parity lanes sit in line with their bytes
  always_comb begin
    a_base = (MODE == MODE_SHIFT) ? int'(sh_ptr_r) * SHIFT_W
                                  : int'(a_ent) * WIDTH_A;
    b_base = int'(b_ent) * WIDTH_B;
  end

  // storage has no reset and no preload, so unwritten bits stay unknown
  always_ff @(posedge mclk) begin
    if (b_wr) begin
      for (int i = 0; i < WIDTH_B; i++) begin
        mem[b_base + i] <= pb.wdata_q[i];
      end
    end
    if (a_wr) begin // port a wins a same-bit collision
      for (int i = 0; i < WIDTH_A; i++) begin
        if (MODE != MODE_SHIFT || i < SHIFT_W) begin
          mem[a_base + i] <= pa.wdata_q[i];
        end
      end
    end
  end

  // ****************************************************************
  // read paths
  // ****************************************************************
  // port a read, or all shift taps side by side, before this edge's write
  always_comb begin
    int ent;
    ent = 0;
    pa.rd_data = '0;
    if (MODE == MODE_SHIFT) begin
      for (int k = 0; k < SHIFT_TAPS; k++) begin
        ent = (int'(sh_ptr_r) + SH_LEN - (k + 1) * SHIFT_DEPTH) % SH_LEN;
        for (int j = 0; j < SHIFT_W; j++) begin
          pa.rd_data[k * SHIFT_W + j] = mem[ent * SHIFT_W + j];
        end
      end
    end else begin
      for (int i = 0; i < WIDTH_A; i++) begin
        pa.rd_data[i] = mem[a_base + i];
      end
    end
    pa.rd_load = a_rl;
  end

  // port b read
  always_comb begin
    for (int i = 0; i < WIDTH_B; i++) begin
      pb.rd_data[i] = mem[b_base + i];
    end
    pb.rd_load = b_rl;
  end

  // ****************************************************************
  // fifo control
  // ****************************************************************
  assign push    = (MODE == MODE_FIFO) && a_wr;
  assign pop     = (MODE == MODE_FIFO) && b_rl;
  assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);

  // pointers advance on accepted push and pop
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end

  // fill count and flags
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r   <= '0;
      full_r  <= 1'b0;
      empty_r <= 1'b1;
    end else begin
      cnt_r   <= cnt_nxt;
      full_r  <= cnt_nxt == CW'(DEPTH_A);
      empty_r <= cnt_nxt == '0;
    end
  end

  assign fifo_full  = full_r;
  assign fifo_empty = empty_r;

  // ****************************************************************
  // shift pointer
  // ****************************************************************
  // circular write position of the shift line
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sh_ptr_r <= '0;
    end else if (MODE == MODE_SHIFT && a_wr) begin
      sh_ptr_r <= (sh_ptr_r == SH_AW'(SH_LEN - 1)) ? '0 : sh_ptr_r + 1'b1;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_shape_legal: assert property (
    LEGAL)
    else $error("shape and mode pairing not offered");

  a_shift_length: assert property (
    MODE == MODE_SHIFT |-> SH_LEN * SHIFT_W <= SHIFT_MAX_BITS)
    else $error("shift line longer than the block");

  a_store_size: assert property (
    KIND == BLK_LARGE |-> MEM_BITS == LARGE_PAR_BITS
                          && DEPTH_A * WIDTH_A <= MEM_BITS)
    else $error("large block storage size wrong");

  a_fifo_bound: assert property (
    MODE == MODE_FIFO |-> cnt_r <= CW'(DEPTH_A) && (full_r == (cnt_r == CW'(DEPTH_A)))
                          && !(full_r && a_wr))
    else $error("fifo count or full flag wrong");

  a_fifo_empty: assert property (
    (MODE == MODE_FIFO && empty_r && pb.en_q)
      |-> !pop ##1 $stable(rp_r))
    else $error("pop taken from an empty fifo");

  a_sdp_roles: assert property (
    MODE == MODE_SDP |-> !b_wr && !a_rl)
    else $error("simple dual-port roles broken");

  // case equality so that an unwritten word read back still matches
  a_read_lat_a: assert property (
    a_rl |-> ##LAT_A a_rdata === $past(pa.rd_data, LAT_A))
    else $error("port a read latency wrong");

  a_read_lat_b: assert property (
    b_rl |-> ##LAT_B b_rdata === $past(pb.rd_data, LAT_B))
    else $error("port b read latency wrong");

  a_lane_readback: assert property (
    ((MODE == MODE_TDP || MODE == MODE_SP) && a_wr && !b_wr)
      ##1 (a_rl && pa.addr_q == $past(pa.addr_q))
      |-> pa.rd_data == $past(pa.wdata_q))
    else $error("written word with parity lanes not read back");

endmodule : configurable_ram_blocks

// ### rtl/ram_cfg_pkg.sv
// shapes, modes and size constants of the configurable ram blocks
// assumes: used by the ram core, its port units and the bench only
package ram_cfg_pkg;

  // ****************************************************************
  // block kinds and operating modes
  // ****************************************************************
  typedef enum logic [0:0] {
    BLK_MID   = 1'b0,
    BLK_LARGE = 1'b1
  } blk_kind_e;

  typedef enum logic [2:0] {
    MODE_TDP   = 3'b000,
    MODE_SDP   = 3'b001,
    MODE_SP    = 3'b010,
    MODE_FIFO  = 3'b011,
    MODE_SHIFT = 3'b100
  } ram_mode_e;

  // ****************************************************************
  // storage sizes and width limits
  // ****************************************************************
  localparam int MID_BITS       = 32'h0000_1000; // 4,096 data bits
  localparam int MID_PAR_BITS   = 32'h0000_1200; // 4,608 with parity
  localparam int LARGE_BITS     = 32'h0008_0000; // 524,288 data bits
  localparam int LARGE_PAR_BITS = 32'h0009_0000; // 589,824 with parity
  localparam int SHIFT_MAX_BITS = 32'h0000_1200; // 4,608 shift bits
  localparam int MID_TDP_MAX_W  = 32'h0000_0012; // widest mid true dual-port width
  localparam int LARGE_TOP_W    = 32'h0000_0080; // 4K-deep large shapes
  localparam int LARGE_DRIVERS  = 32'h0000_0090; // read drivers, both ports
  localparam int LANE_W         = 32'h0000_0009; // byte plus parity bit

  // parity-set widths are whole 9-bit lanes
  function automatic bit is_par(int w);
    return (w % LANE_W) == 0;
  endfunction : is_par

  // widths that each block offers
  function automatic bit width_ok(blk_kind_e k, int w);
    if (k == BLK_MID) begin
      return w inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20,
                       8'h09, 8'h12, 8'h24};
    end
    return w inside {8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
                     8'h09, 8'h12, 8'h24, 8'h48, 8'h90};
  endfunction : width_ok

  // bits of the bank seen at a width
  function automatic int bank_bits(blk_kind_e k, int w);
    if (k == BLK_MID) begin
      return is_par(w) ? MID_PAR_BITS : MID_BITS;
    end
    return is_par(w) ? LARGE_PAR_BITS : LARGE_BITS;
  endfunction : bank_bits

  function automatic int depth_of(blk_kind_e k, int w);
    return (w < 1) ? 1 : bank_bits(k, w) / w;
  endfunction : depth_of

  // legal shape and mode pairings
  function automatic bit pair_ok(blk_kind_e k, ram_mode_e m, int wa, int wb);
    if (!width_ok(k, wa) || !width_ok(k, wb) || is_par(wa) != is_par(wb)) begin
      return 1'b0;
    end
    case (m)
      MODE_TDP: begin
        if (k == BLK_MID) begin
          return wa <= MID_TDP_MAX_W && wb <= MID_TDP_MAX_W;
        end
        return wa + wb <= LARGE_DRIVERS;
      end
      MODE_SDP: begin
        if (k == BLK_MID) begin
          return 1'b1;
        end
        return wa == wb || (wa < LARGE_TOP_W && wb < LARGE_TOP_W);
      end
      MODE_SP:    return wa == wb;
      MODE_FIFO:  return k == BLK_LARGE && wa == wb;
      MODE_SHIFT: return k == BLK_MID;
      default:    return 1'b0;
    endcase
  endfunction : pair_ok

endpackage : ram_cfg_pkg

// ### rtl/ram_port_if.sv
// registered port signals between a port unit and the ram core
// assumes: one instance per port, both ends on mclk
`timescale 1ns/1ps
interface ram_port_if #(
  parameter int W  = 16,
  parameter int AW = 8
);
  logic          en_q;
  logic          we_q;
  logic [AW-1:0] addr_q;
  logic [W-1:0]  wdata_q;
  logic [W-1:0]  rd_data;
  logic          rd_load;

  modport unit (output en_q, we_q, addr_q, wdata_q, input rd_data, rd_load);
  modport core (input en_q, we_q, addr_q, wdata_q, output rd_data, rd_load);
endinterface : ram_port_if

// ### rtl/ram_port_unit.sv
// one ram port: input registers and optional output register
// assumes: core reads storage combinationally from the registered address
`timescale 1ns/1ps
module ram_port_unit
  import ram_cfg_pkg::*;
#(
  parameter int W       = 16,
  parameter int AW      = 8,
  parameter bit OUT_REG = 1'b1
) (
  input  wire logic          mclk,
  input  wire logic          reset_n,
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [W-1:0]  wdata,
  ram_port_if.unit           p,
  output logic      [W-1:0]  rdata
);

  logic [W-1:0] rd1_r;

  // ****************************************************************
  // input stage
  // ****************************************************************
  // every input is captured on the clock edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      p.en_q    <= 1'b0;
      p.we_q    <= 1'b0;
      p.addr_q  <= '0;
      p.wdata_q <= '0;
    end else begin
      p.en_q    <= en;
      p.we_q    <= we;
      p.addr_q  <= addr;
      p.wdata_q <= wdata;
    end
  end

  // ****************************************************************
  // read stage
  // ****************************************************************
  // first read register, loaded only on an accepted read
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd1_r <= '0;
    end else if (p.rd_load) begin
      rd1_r <= p.rd_data;
    end
  end

  // output register kept or bypassed at build time
  generate
    if (OUT_REG) begin : g_out
      logic [W-1:0] out_r;
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          out_r <= '0;
        end else begin
          out_r <= rd1_r;
        end
      end
      assign rdata = out_r;
    end else begin : g_byp
      assign rdata = rd1_r;
    end
  endgenerate

  a_in_capture: assert property (@(posedge mclk) disable iff (!reset_n)
    en |=> p.en_q && p.we_q == $past(we) && p.addr_q == $past(addr)
           && p.wdata_q == $past(wdata))
    else $error("port inputs not captured on the edge");

endmodule : ram_port_unit

// ### sim/fabric_user.sv
// fabric-side user logic that drives both ports of the ram block
// assumes: bench calls its tasks at a falling edge of mclk
`timescale 1ns/1ps
module fabric_user #(
  parameter int WA   = 16,
  parameter int WB   = 8,
  parameter int AW_A = 8,
  parameter int AW_B = 9
) (
  input  wire logic            mclk,
  output logic                 a_en,
  output logic                 a_we,
  output logic      [AW_A-1:0] a_addr,
  output logic      [WA-1:0]   a_wdata,
  output logic                 b_en,
  output logic                 b_we,
  output logic      [AW_B-1:0] b_addr,
  output logic      [WB-1:0]   b_wdata
);
  // ****************************************************************
  // request tasks
  // ****************************************************************
  // only a legal true dual-port pairing (16 with 8) is ever built
  initial begin
    a_en    = 1'b0;
    a_we    = 1'b0;
    a_addr  = '0;
    a_wdata = '0;
    b_en    = 1'b0;
    b_we    = 1'b0;
    b_addr  = '0;
    b_wdata = '0;
  end

  // one request held for exactly one rising edge
  task automatic a_req(input logic we, input logic [AW_A-1:0] addr, input logic [WA-1:0] d);
    a_en    = 1'b1;
    a_we    = we;
    a_addr  = addr;
    a_wdata = d;
    @(negedge mclk);
  endtask : a_req

  task automatic b_req(input logic we, input logic [AW_B-1:0] addr, input logic [WB-1:0] d);
    b_en    = 1'b1;
    b_we    = we;
    b_addr  = addr;
    b_wdata = d;
    @(negedge mclk);
  endtask : b_req

  // released lines flip so stale values never look valid
  task automatic idle_a();
    a_en    = 1'b0;
    a_we    = ~a_we;
    a_addr  = ~a_addr;
    a_wdata = ~a_wdata;
    @(negedge mclk);
  endtask : idle_a

  task automatic idle_b();
    b_en    = 1'b0;
    b_we    = ~b_we;
    b_addr  = ~b_addr;
    b_wdata = ~b_wdata;
    @(negedge mclk);
  endtask : idle_b
endmodule : fabric_user

// ### sim/configurable_ram_blocks_bench.sv
// self-checking bench: mid block, true dual-port, 256 x16 with 512 x8
// assumes: design body keeps its own assertions; port a registered out
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module configurable_ram_blocks_bench;
  import ram_cfg_pkg::*;
  localparam int AW_A = 8;
  localparam int AW_B = 9;
  localparam int WA   = 16; // port a width
  localparam int WB   = 8;  // port b width

  typedef struct {
    logic [7:0]  addr;
    logic [15:0] data;
  } row_s;

  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        a_en;
  logic        a_we;
  logic [7:0]  a_addr;
  logic [15:0] a_wdata;
  logic [15:0] a_rdata;
  logic        b_en;
  logic        b_we;
  logic [8:0]  b_addr;
  logic [7:0]  b_wdata;
  logic [7:0]  b_rdata;
  logic        fifo_full;
  logic        fifo_empty;
  int          mismatches = 0;
  int          n_tests = 0;
  row_s        rows [4] = '{'{8'h00, 16'h0000}, '{8'hFF, 16'hFFFF},
                            '{8'h01, 16'hA55A}, '{8'h80, 16'h1234}};

  // ****************************************************************
  // clock, design and partner
  // ****************************************************************
  always #2 mclk = ~mclk;

  configurable_ram_blocks #(
    .MODE(MODE_TDP), .WIDTH_A(WA), .WIDTH_B(WB),
    .OUT_REG_A(1'b1), .OUT_REG_B(1'b0)
  ) configurable_ram_blocks_inst (
    .mclk(mclk), .reset_n(reset_n),
    .a_en(a_en), .a_we(a_we), .a_addr(a_addr), .a_wdata(a_wdata), .a_rdata(a_rdata),
    .b_en(b_en), .b_we(b_we), .b_addr(b_addr), .b_wdata(b_wdata), .b_rdata(b_rdata),
    .fifo_full(fifo_full), .fifo_empty(fifo_empty)
  );

  fabric_user #(.WA(WA), .WB(WB), .AW_A(AW_A), .AW_B(AW_B)) fabric_user_inst (
    .mclk(mclk), .a_en(a_en), .a_we(a_we), .a_addr(a_addr), .a_wdata(a_wdata),
    .b_en(b_en), .b_we(b_we), .b_addr(b_addr), .b_wdata(b_wdata)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  // port a read result lands three edges after the request
  task automatic rd_a(input logic [7:0] addr, input logic [15:0] exp, input string nm);
    fabric_user_inst.a_req(1'b0, addr, 16'h0000);
    repeat (3) fabric_user_inst.idle_a();
    `CHK(nm, a_rdata, exp)
  endtask : rd_a

  // port b has no output register: two edges
  task automatic rd_b(input logic [8:0] addr, input logic [7:0] exp, input string nm);
    fabric_user_inst.b_req(1'b0, addr, 8'h00);
    repeat (2) fabric_user_inst.idle_b();
    `CHK(nm, b_rdata, exp)
  endtask : rd_b

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  // ****************************************************************
  // watchdog
  // ****************************************************************
  initial begin
    repeat (3000) @(posedge mclk);
    mismatches++;
    $display("ERROR watchdog expected done seen hang");
    summarize();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    // reset held five cycles, outputs checked while it holds
    repeat (3) @(negedge mclk);
    `CHK("rst a_rdata", a_rdata, 16'h0000)
    `CHK("rst b_rdata", b_rdata, 8'h00)
    `CHK("rst fifo_empty", fifo_empty, 1'b1)
    `CHK("rst fifo_full", fifo_full, 1'b0)
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    $display("test reset done");

    // never-written word reads undefined
    rd_b(9'h1F0, 8'hXX, "unwritten");
    $display("test unwritten done");

    // table: wide write, wide read on the very next cycle, then narrow lanes
    foreach (rows[i]) begin
      fabric_user_inst.a_req(1'b1, rows[i].addr, rows[i].data);
      rd_a(rows[i].addr, rows[i].data, "wide word");
      rd_b({rows[i].addr, 1'b0}, rows[i].data[7:0], "low lane");
      rd_b({rows[i].addr, 1'b1}, rows[i].data[15:8], "high lane");
    end
    $display("test table done");

    // narrow write lands in the high byte of wide word 1
    fabric_user_inst.b_req(1'b1, 9'h003, 8'hC3);
    fabric_user_inst.idle_b();
    rd_a(8'h01, 16'hC35A, "narrow into wide");
    $display("test mixed width done");

    // write then read next cycle sees new data; read in same cycle sees old
    fork
      fabric_user_inst.a_req(1'b1, 8'h80, 16'h7E81);
      fabric_user_inst.b_req(1'b0, 9'h100, 8'h00);
    join
    fork
      fabric_user_inst.idle_a();
      fabric_user_inst.b_req(1'b0, 9'h100, 8'h00);
    join
    `CHK("old on collision", b_rdata, 8'h34)
    fabric_user_inst.idle_b();
    `CHK("new after write", b_rdata, 8'h81)
    $display("test read during write done");

    // both ports write the same byte: port a wins
    fork
      fabric_user_inst.a_req(1'b1, 8'h00, 16'hBEEF);
      fabric_user_inst.b_req(1'b1, 9'h000, 8'h11);
    join
    fork
      fabric_user_inst.idle_a();
      fabric_user_inst.idle_b();
    join
    rd_b(9'h000, 8'hEF, "port a wins");
    $display("test write collision done");

    // registered port a: old result one edge after the take, new after two
    rd_a(8'hFF, 16'hFFFF, "prior read");
    fabric_user_inst.a_req(1'b0, 8'h80, 16'h0000);
    fabric_user_inst.idle_a();
    `CHK("still old result", a_rdata, 16'hFFFF)
    fabric_user_inst.idle_a();
    `CHK("registered result", a_rdata, 16'h7E81)
    $display("test output register done");

    // a second reset clears outputs but not storage
    reset_n = 1'b0;
    @(negedge mclk);
    `CHK("rerst a_rdata", a_rdata, 16'h0000)
    reset_n = 1'b1;
    rd_a(8'h80, 16'h7E81, "kept over reset");
    $display("test second reset done");
    summarize();
  end
endmodule : configurable_ram_blocks_bench
